// ===== dv/cpu_side_model.sv
// cpu core model issuing the halt instruction
// assumes go is a one-cycle request from the bench
`timescale 1ns/10ps
`default_nettype none
module cpu_side_model (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic go,
    output logic      halt_exec
);
    logic [2:0] nop_cnt;
    // one halt pulse, then five nop slots
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            halt_exec <= 1'b0;
            nop_cnt   <= 3'h0;
        end else if (go && nop_cnt == 3'h0) begin
            halt_exec <= 1'b1;
            nop_cnt   <= 3'h5;
        end else begin
            halt_exec <= 1'b0;
            nop_cnt   <= (nop_cnt == 3'h0) ? 3'h0 : nop_cnt - 3'h1;
        end
    end
endmodule : cpu_side_model
`default_nettype wire

// ===== dv/halt_ctl_asserts.sv
// port checker for the halt and standby control block
// assumes bind onto halt_standby_ctl, one clock domain
`timescale 1ns/10ps
`default_nettype none
module halt_ctl_asserts (
    input wire logic                            ref_clk,
    input wire logic                            rst_n,
    input wire logic                            psel,
    input wire logic                            penable,
    input wire logic                            pwrite,
    input wire logic                            pready,
    input wire logic                            halt_exec,
    input wire logic [31:0]                     paddr,
    input wire logic [31:0]                     prdata,
    input wire logic [halt_ctl_pkg::prio_w-1:0] mask_prio,
    input wire logic [halt_ctl_pkg::prio_w-1:0] serv_prio,
    input wire logic                            watchdog_nmi_request,
    input wire logic                            mask_req,
    input wire logic                            in_service,
    input wire logic                            int_enable,
    input wire logic                            reset_pin_req,
    input wire logic                            watchdog_overflow_reset,
    input wire logic                            low_voltage_reset,
    input wire logic                            power_on_clear_reset,
    input wire logic                            cpu_clk_en,
    input wire logic                            periph_clk_en,
    input wire logic                            osc_run,
    input wire logic                            halted,
    input wire logic                            light_standby,
    input wire logic                            deep_standby,
    input wire logic                            wake_pulse,
    input wire logic                            wake_ack,
    input wire logic                            wake_to_nmi,
    input wire logic                            sys_reset_req,
    input wire logic                            keep_lvd_on,
    input wire logic                            keep_poc_on
);
    logic rs, run, mw;
    assign rs = reset_pin_req | watchdog_overflow_reset | low_voltage_reset | power_on_clear_reset;
    assign run = !halted && !light_standby && !deep_standby;
    assign mw = halted && mask_req && !watchdog_nmi_request && int_enable && in_service && !rs;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_rd_zero;
        psel && penable && pready && !pwrite && paddr == halt_ctl_pkg::kind_select_addr
            |-> prdata[31:1] == 31'h0;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("kind select upper bits set");
    property p_enter; halt_exec && run && !rs && !psel |=> halted; endproperty
    a_enter: assert property (p_enter) else $error("halt not entered");
    property p_gate_off; $rose(halted) && !rs |-> ##[0:1] !cpu_clk_en; endproperty
    a_gate_off: assert property (p_gate_off) else $error("cpu clock not gated");
    property p_halt_clk; halted |-> periph_clk_en && osc_run; endproperty
    a_halt_clk: assert property (p_halt_clk) else $error("clock stopped in halt");
    property p_keep; keep_lvd_on && keep_poc_on; endproperty
    a_keep: assert property (p_keep) else $error("monitor enable dropped");
    property p_nmi;
        halted && watchdog_nmi_request && int_enable && !rs |=> !halted && wake_pulse && wake_to_nmi;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi wake missing");
    property p_di;
        halted && mask_req && !watchdog_nmi_request && !int_enable |=> !wake_ack && !wake_to_nmi;
    endproperty
    a_di: assert property (p_di) else $error("interrupt taken while disabled");
    property p_low; mw && mask_prio >= serv_prio |=> !wake_ack; endproperty
    a_low: assert property (p_low) else $error("low priority acknowledged");
    property p_high; mw && mask_prio < serv_prio |=> !wake_pulse || wake_ack; endproperty
    a_high: assert property (p_high) else $error("high priority not acknowledged");
    property p_rst; rs |=> sys_reset_req && run; endproperty
    a_rst: assert property (p_rst) else $error("reset source did not reset");
    property p_reopen; $rose(cpu_clk_en) |-> run; endproperty
    a_reopen: assert property (p_reopen) else $error("cpu clock reopened early");
    c_nmi: cover property (wake_to_nmi);
    c_ack: cover property (wake_ack);
    c_light: cover property (light_standby);
    c_deep: cover property (deep_standby);
endmodule : halt_ctl_asserts
bind halt_standby_ctl halt_ctl_asserts halt_ctl_asserts_i (
    .ref_clk, .rst_n, .psel, .penable, .pwrite, .pready, .halt_exec, .paddr, .prdata, .mask_prio,
    .serv_prio, .watchdog_nmi_request, .mask_req, .in_service, .int_enable, .reset_pin_req,
    .watchdog_overflow_reset, .low_voltage_reset, .power_on_clear_reset, .cpu_clk_en,
    .periph_clk_en, .osc_run, .halted, .light_standby, .deep_standby, .wake_pulse, .wake_ack,
    .wake_to_nmi, .sys_reset_req, .keep_lvd_on, .keep_poc_on
);
`default_nettype wire

// ===== dv/test_cpu_halt_standby_control.sv
// self-checking bench for halt, wakeup and standby control
// assumes the cpu model drives halt_exec, bench drives apb and requests
`timescale 1ns/10ps
`default_nettype none
module test_cpu_halt_standby_control;
    localparam logic [31:0] ks = halt_ctl_pkg::kind_select_addr;
    localparam logic [31:0] ps = halt_ctl_pkg::power_save_addr;
    logic        ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        go = 1'b0, nmi = 1'b0, mask_req = 1'b0, in_service = 1'b0, int_enable = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
    logic [3:0]  pstrb = 4'hf, rsrc = 4'h0;
    logic [halt_ctl_pkg::prio_w-1:0] mask_prio = '0, serv_prio = '0;
    logic        pready, pslverr, halt_exec, cpu_clk_en, periph_clk_en, osc_run, halted, err;
    logic        light_standby, deep_standby, wake_pulse, wake_ack, wake_to_nmi, wake_resume;
    logic        sys_reset_req, keep_lvd_on, keep_poc_on;
    int          bad_count = 0, num_checks = 0;
    halt_standby_ctl halt_standby_ctl_i (
        .ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
        .pslverr, .halt_exec, .watchdog_nmi_request(nmi), .mask_req, .mask_prio, .serv_prio,
        .in_service, .int_enable, .reset_pin_req(rsrc[0]), .watchdog_overflow_reset(rsrc[1]),
        .low_voltage_reset(rsrc[2]), .power_on_clear_reset(rsrc[3]), .cpu_clk_en, .periph_clk_en,
        .osc_run, .halted, .light_standby, .deep_standby, .wake_pulse, .wake_ack, .wake_to_nmi,
        .wake_resume, .sys_reset_req, .keep_lvd_on, .keep_poc_on
    );
    cpu_side_model cpu_side_model_i (.ref_clk, .rst_n, .go, .halt_exec);
    always #2 ref_clk = ~ref_clk;
    task chk(input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    task apb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wait_halt(input logic v);
        int n;
        n = 0;
        #1;
        while (halted !== v && n < 40) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk({31'h0, halted}, {31'h0, v});
    endtask : wait_halt
    task halt_now;
        @(posedge ref_clk);
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        wait_halt(1'b1);
    endtask : halt_now
    task run_wake(input logic pre, nm, ie, sv, input logic [2:0] mp, sp, ex);
        @(posedge ref_clk);
        int_enable <= ie;
        in_service <= sv;
        mask_prio  <= mp;
        serv_prio  <= sp;
        mask_req   <= pre & !nm;
        nmi        <= pre & nm;
        halt_now();
        if (!pre) begin
            @(posedge ref_clk);
            mask_req <= !nm;
            nmi      <= nm;
            #1 chk({29'h0, cpu_clk_en, periph_clk_en, osc_run}, 32'h3);
        end
        wait_halt(1'b0);
        chk({28'h0, wake_pulse, wake_ack, wake_to_nmi, wake_resume}, {28'h0, 1'b1, ex});
        repeat (3) @(posedge ref_clk);
        #1 chk({31'h0, cpu_clk_en}, 32'h1);
        @(posedge ref_clk);
        mask_req <= 1'b0;
        nmi      <= 1'b0;
    endtask : run_wake
    initial begin
        #40000;
        bad_count++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        #1 chk({26'h0, keep_lvd_on, keep_poc_on, periph_clk_en, osc_run, cpu_clk_en, halted},
               32'h3e);
        @(posedge ref_clk) rst_n <= 1'b1;
        apb(1'b0, ks, 32'h0, q);
        chk(q, 32'h0);
        apb(1'b1, ks, 32'hffffffff, q);
        apb(1'b0, ks, 32'h0, q);
        chk(q, 32'h1);
        pstrb <= 4'he;
        apb(1'b1, ks, 32'h0, q);
        apb(1'b0, ks, 32'h0, q);
        chk(q, 32'h1);
        pstrb <= 4'hf;
        apb(1'b0, 32'hfffff830, 32'h0, q);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, ks, 32'h0, q);
        run_wake(1'b0, 1'b1, 1'b1, 1'b0, 3'h0, 3'h0, 3'b010);
        run_wake(1'b0, 1'b0, 1'b0, 1'b0, 3'h2, 3'h4, 3'b001);
        run_wake(1'b0, 1'b0, 1'b1, 1'b1, 3'h3, 3'h3, 3'b001);
        run_wake(1'b0, 1'b0, 1'b1, 1'b1, 3'h1, 3'h3, 3'b100);
        run_wake(1'b1, 1'b0, 1'b1, 1'b0, 3'h5, 3'h0, 3'b100);
        apb(1'b1, ps, 32'h10, q);
        halt_now();
        @(posedge ref_clk) mask_req <= 1'b1;
        repeat (5) @(posedge ref_clk);
        #1 chk({31'h0, halted}, 32'h1);
        apb(1'b0, halt_ctl_pkg::status_addr, 32'h0, q);
        chk(q, 32'h1);
        @(posedge ref_clk) nmi <= 1'b1;
        wait_halt(1'b0);
        @(posedge ref_clk) nmi <= 1'b0;
        mask_req <= 1'b0;
        apb(1'b1, ps, 32'h0, q);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ks, 32'h1, q);
            halt_now();
            @(posedge ref_clk) rsrc <= 4'h1 << i;
            @(posedge ref_clk) rsrc <= 4'h0;
            #1 chk({30'h0, halted, sys_reset_req}, 32'h1);
            apb(1'b0, ks, 32'h0, q);
            chk(q, 32'h0);
        end
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, ks, 32'(k), q);
            apb(1'b1, ps, 32'h2, q);
            @(posedge ref_clk);
            #1 chk({29'h0, light_standby, deep_standby, osc_run}, k ? 32'h2 : 32'h5);
            @(posedge ref_clk) mask_req <= 1'b1;
            repeat (3) @(posedge ref_clk);
            #1 chk({30'h0, light_standby, deep_standby}, 32'h0);
            @(posedge ref_clk) mask_req <= 1'b0;
            apb(1'b0, ps, 32'h0, q);
            chk(q, 32'h0);
        end
        test_done();
    end
endmodule : test_cpu_halt_standby_control
`default_nettype wire

// ===== rtl/cpu_clock_gate.sv
// latch-free glitch-safe cpu clock enable
// assumes the enable is sampled on the falling edge by a downstream icg cell
`timescale 1ns/10ps
`default_nettype none
module cpu_clock_gate (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic run_req,
    output logic      cpu_clk_en
);
    logic run_sync_reg;
    // two-stage enable so reopening lands on whole cycles only
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_sync_reg <= 1'b1;
            cpu_clk_en   <= 1'b1;
        end else begin
            run_sync_reg <= run_req;
            cpu_clk_en   <= run_sync_reg & run_req;
        end
    end
endmodule : cpu_clock_gate
`default_nettype wire

// ===== rtl/halt_ctl_pkg.sv
// constants shared by the halt and standby control block
// assumes apb slave with 32-bit data, one aligned word per register
package halt_ctl_pkg;
    localparam logic [31:0] kind_select_addr   = 32'hfffff820;
    localparam logic [31:0] power_save_addr    = 32'hfffff824;
    localparam logic [31:0] status_addr        = 32'hfffff828;
    localparam logic [7:0]  kind_select_reset  = 8'h00;
    localparam logic [7:0]  power_save_reset   = 8'h00;
    localparam int          deep_select_pos    = 0;
    localparam int          standby_req_pos    = 1;
    localparam int          wake_inhibit_pos   = 4;
    localparam int          stat_halt_pos      = 0;
    localparam int          stat_light_pos     = 1;
    localparam int          stat_deep_pos      = 2;
    localparam int          stat_gate_pos      = 3;
    localparam int          prio_w             = 3;
    typedef enum logic [1:0] {run_st, halt_st, light_st, deep_st} mode_t;
    typedef enum logic [1:0] {wake_none_t, wake_resume_t, wake_ack_t, wake_nmi_t} wake_kind_t;
endpackage : halt_ctl_pkg

// ===== rtl/halt_standby_ctl.sv
// halt entry and wakeup, standby selection, apb register slave
// assumes cpu pulses halt_exec and reset sources are synchronous pulses or levels
//
// Our own choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module halt_standby_ctl (
    input  wire logic                            ref_clk,
    input  wire logic                            rst_n,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [31:0]                     paddr,
    input  wire logic [31:0]                     pwdata,
    input  wire logic [3:0]                      pstrb,
    output logic                                 pready,
    output logic [31:0]                          prdata,
    output logic                                 pslverr,
    input  wire logic                            halt_exec,
    input  wire logic                            watchdog_nmi_request,
    input  wire logic                            mask_req,
    input  wire logic [halt_ctl_pkg::prio_w-1:0] mask_prio,
    input  wire logic [halt_ctl_pkg::prio_w-1:0] serv_prio,
    input  wire logic                            in_service,
    input  wire logic                            int_enable,
    input  wire logic                            reset_pin_req,
    input  wire logic                            watchdog_overflow_reset,
    input  wire logic                            low_voltage_reset,
    input  wire logic                            power_on_clear_reset,
    output logic                                 cpu_clk_en,
    output logic                                 periph_clk_en,
    output logic                                 osc_run,
    output logic                                 halted,
    output logic                                 light_standby,
    output logic                                 deep_standby,
    output logic                                 wake_pulse,
    output logic                                 wake_ack,
    output logic                                 wake_to_nmi,
    output logic                                 wake_resume,
    output logic                                 sys_reset_req,
    output logic                                 keep_lvd_on,
    output logic                                 keep_poc_on
);
    logic [7:0]                 kind_select_reg;
    logic [7:0]                 power_save_reg;
    halt_ctl_pkg::mode_t        mode_reg;
    halt_ctl_pkg::mode_t        mode_next;
    halt_ctl_pkg::wake_kind_t   kind;
    logic                       wake;
    logic                       any_reset;
    logic                       gate_en;
    logic                       wr_en;
    logic                       rd_en;
    logic                       addr_ok;
    logic [31:0]                rdata_next;

    function automatic logic mapped(input logic [31:0] a);
        mapped = (a == halt_ctl_pkg::kind_select_addr) ||
                 (a == halt_ctl_pkg::power_save_addr) ||
                 (a == halt_ctl_pkg::status_addr);
    endfunction : mapped

    assign any_reset = reset_pin_req | watchdog_overflow_reset |
                       low_voltage_reset | power_on_clear_reset;
    assign addr_ok = mapped(paddr);
    assign wr_en   = psel & penable & pwrite & addr_ok & pstrb[0];
    assign rd_en   = psel & penable & ~pwrite;

    wake_decide u_wake (
        .nmi_req      (watchdog_nmi_request),
        .mask_req     (mask_req),
        .mask_prio    (mask_prio),
        .serv_prio    (serv_prio),
        .in_service   (in_service),
        .int_enable   (int_enable),
        .wake_inhibit (power_save_reg[halt_ctl_pkg::wake_inhibit_pos]),
        .wake         (wake),
        .kind         (kind)
    );

    cpu_clock_gate u_gate (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .run_req    (mode_next == halt_ctl_pkg::run_st),
        .cpu_clk_en (gate_en)
    );

    // kind select register, byte lane 0 only
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            kind_select_reg <= halt_ctl_pkg::kind_select_reset;
        end else if (any_reset) begin
            kind_select_reg <= halt_ctl_pkg::kind_select_reset;
        end else if (wr_en && paddr == halt_ctl_pkg::kind_select_addr) begin
            kind_select_reg <= {7'h00, pwdata[halt_ctl_pkg::deep_select_pos]};
        end
    end

    // power save control: request bit clears once standby is left
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_save_reg <= halt_ctl_pkg::power_save_reset;
        end else if (any_reset) begin
            power_save_reg <= halt_ctl_pkg::power_save_reset;
        end else if (wr_en && paddr == halt_ctl_pkg::power_save_addr) begin
            power_save_reg[halt_ctl_pkg::standby_req_pos] <=
                pwdata[halt_ctl_pkg::standby_req_pos];
            power_save_reg[halt_ctl_pkg::wake_inhibit_pos] <=
                pwdata[halt_ctl_pkg::wake_inhibit_pos];
        end else if (mode_reg != halt_ctl_pkg::run_st && mode_next == halt_ctl_pkg::run_st) begin
            power_save_reg[halt_ctl_pkg::standby_req_pos] <= 1'b0;
        end
    end

    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            halt_ctl_pkg::run_st: begin
                if (power_save_reg[halt_ctl_pkg::standby_req_pos]) begin
                    mode_next = kind_select_reg[halt_ctl_pkg::deep_select_pos]
                              ? halt_ctl_pkg::deep_st
                              : halt_ctl_pkg::light_st;
                end else if (halt_exec) begin
                    mode_next = halt_ctl_pkg::halt_st;
                end
            end
            halt_ctl_pkg::halt_st: begin
                if (wake) begin
                    mode_next = halt_ctl_pkg::run_st;
                end
            end
            halt_ctl_pkg::light_st,
            halt_ctl_pkg::deep_st: begin
                if (mask_req && !power_save_reg[halt_ctl_pkg::wake_inhibit_pos]) begin
                    mode_next = halt_ctl_pkg::run_st;
                end
            end
        endcase
        if (any_reset) begin
            mode_next = halt_ctl_pkg::run_st;
        end
    end

    // mode: entered halt lasts at least one cycle even if wake pending
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= halt_ctl_pkg::run_st;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // mode outputs and clock enables
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_clk_en    <= 1'b1;
            periph_clk_en <= 1'b1;
            osc_run       <= 1'b1;
            halted        <= 1'b0;
            light_standby <= 1'b0;
            deep_standby  <= 1'b0;
            keep_lvd_on   <= 1'b1;
            keep_poc_on   <= 1'b1;
        end else begin
            cpu_clk_en    <= gate_en;
            periph_clk_en <= (mode_next == halt_ctl_pkg::run_st) ||
                             (mode_next == halt_ctl_pkg::halt_st);
            osc_run       <= mode_next != halt_ctl_pkg::deep_st;
            halted        <= mode_next == halt_ctl_pkg::halt_st;
            light_standby <= mode_next == halt_ctl_pkg::light_st;
            deep_standby  <= mode_next == halt_ctl_pkg::deep_st;
            keep_lvd_on   <= 1'b1;
            keep_poc_on   <= 1'b1;
        end
    end

    // one-cycle wake result pulses and the registered reset request
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_pulse    <= 1'b0;
            wake_ack      <= 1'b0;
            wake_to_nmi   <= 1'b0;
            wake_resume   <= 1'b0;
            sys_reset_req <= 1'b0;
        end else begin
            wake_pulse    <= (mode_reg == halt_ctl_pkg::halt_st) & wake & ~any_reset;
            wake_ack      <= (mode_reg == halt_ctl_pkg::halt_st) & ~any_reset &
                             (kind == halt_ctl_pkg::wake_ack_t);
            wake_to_nmi   <= (mode_reg == halt_ctl_pkg::halt_st) & ~any_reset &
                             (kind == halt_ctl_pkg::wake_nmi_t);
            wake_resume   <= (mode_reg == halt_ctl_pkg::halt_st) & ~any_reset &
                             (kind == halt_ctl_pkg::wake_resume_t);
            sys_reset_req <= any_reset;
        end
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (paddr == halt_ctl_pkg::kind_select_addr) begin
            rdata_next = {24'h00_0000, kind_select_reg};
        end else if (paddr == halt_ctl_pkg::power_save_addr) begin
            rdata_next = {24'h00_0000, power_save_reg};
        end else if (paddr == halt_ctl_pkg::status_addr) begin
            rdata_next[halt_ctl_pkg::stat_halt_pos]  = mode_reg == halt_ctl_pkg::halt_st;
            rdata_next[halt_ctl_pkg::stat_light_pos] = mode_reg == halt_ctl_pkg::light_st;
            rdata_next[halt_ctl_pkg::stat_deep_pos]  = mode_reg == halt_ctl_pkg::deep_st;
            rdata_next[halt_ctl_pkg::stat_gate_pos]  = gate_en;
        end
    end

    // apb: zero wait, answer registered in setup cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            prdata  <= (psel & ~penable & ~pwrite) ? rdata_next : 32'h0000_0000;
            pslverr <= psel & ~penable & ~mapped(paddr);
        end
    end
endmodule : halt_standby_ctl
`default_nettype wire

// ===== rtl/wake_decide.sv
// decides how the cpu leaves halt on an interrupt wakeup
// assumes request inputs are synchronous to ref_clk
`timescale 1ns/10ps
`default_nettype none
module wake_decide (
    input  wire logic                            nmi_req,
    input  wire logic                            mask_req,
    input  wire logic [halt_ctl_pkg::prio_w-1:0] mask_prio,
    input  wire logic [halt_ctl_pkg::prio_w-1:0] serv_prio,
    input  wire logic                            in_service,
    input  wire logic                            int_enable,
    input  wire logic                            wake_inhibit,
    output logic                                 wake,
    output halt_ctl_pkg::wake_kind_t             kind
);
    // lower code is higher priority
    function automatic logic higher(input logic [halt_ctl_pkg::prio_w-1:0] a,
                                    input logic [halt_ctl_pkg::prio_w-1:0] b);
        higher = a < b;
    endfunction : higher

    logic mask_wake;
    always_comb begin
        mask_wake = mask_req & ~wake_inhibit;
        wake      = nmi_req | mask_wake;
        kind      = halt_ctl_pkg::wake_none_t;
        if (nmi_req) begin
            kind = halt_ctl_pkg::wake_nmi_t;
        end else if (mask_wake) begin
            if (!int_enable) begin
                kind = halt_ctl_pkg::wake_resume_t;
            end else if (in_service && !higher(mask_prio, serv_prio)) begin
                kind = halt_ctl_pkg::wake_resume_t;
            end else begin
                kind = halt_ctl_pkg::wake_ack_t;
            end
        end
    end
endmodule : wake_decide
`default_nettype wire
